// >>> core/jtag_config_port_pkg.sv
package jtag_config_port_pkg;

    // ----------------------------------------
    // instruction register
    // ----------------------------------------
    localparam int IR_WIDTH = 5;
    localparam logic [4:0] INSTR_EXTEST = 5'h00;
    localparam logic [4:0] SELECT_CONFIG_REG_INSTR = 5'h01;
    localparam logic [4:0] INSTR_ERASE = 5'h02;
    localparam logic [4:0] READBACK_CONFIG_INSTR = 5'h03;
    localparam logic [4:0] COMMIT_CONFIG_INSTR = 5'h04;
    localparam logic [4:0] INSTR_IDCODE = 5'h0d;
    localparam logic [4:0] INSTR_SAMPLE = 5'h1e;
    localparam logic [4:0] INSTR_BYPASS = 5'h1f;
    localparam logic [4:0] IR_CAPTURE = 5'h01;   // low two bits 01 as the standard asks

    // ----------------------------------------
    // data registers
    // ----------------------------------------
    localparam int ID_WIDTH = 32;
    localparam logic [31:0] ID_VALUE = 32'h1234_5679;   // arbitrary value, bit 0 set
    localparam int SIG_WIDTH = 7;
    localparam int CFG_WIDTH = 24;   // functional bits + signature + lock
    localparam int SIG_LSB = 16;
    localparam int LOCK_POS = 23;

    // ----------------------------------------
    // controller states
    // ----------------------------------------
    typedef enum logic [3:0] {
        TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
        SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
    } tap_state_e;

endpackage

// >>> core/jtag_config_port.sv
`timescale 1ns/1ps
module jtag_config_port #(
    parameter int CFG_W = jtag_config_port_pkg::CFG_WIDTH
) (
    // system
    input wire logic ref_clk,
    input wire logic rst,
    // test port pins
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo,
    output logic tdo_oe,
    // configuration to the analog core
    output logic [CFG_W-1:0] config_bits,
    output logic security_lock_bit,
    output logic [jtag_config_port_pkg::SIG_WIDTH-1:0] user_signature_bits
);

    // ----------------------------------------
    // pin synchronisers and edge detect
    // ----------------------------------------
    logic [1:0] tck_sync, tms_sync, tdi_sync;
    logic tck_prev;
    logic tck_rise, tck_fall;

    // two stages before any logic looks at a pin
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            tck_sync <= 2'b00;
            tms_sync <= 2'b11;
            tdi_sync <= 2'b11;
            tck_prev <= 1'b0;
        end else begin
            tck_sync <= {tck_sync[0], tck};
            tms_sync <= {tms_sync[0], tms};
            tdi_sync <= {tdi_sync[0], tdi};
            tck_prev <= tck_sync[1];
        end
    end

    assign tck_rise = tck_sync[1] & ~tck_prev;
    assign tck_fall = ~tck_sync[1] & tck_prev;

    // ----------------------------------------
    // controller
    // ----------------------------------------
    jtag_config_port_pkg::tap_state_e state, next_state;

    always_comb begin
        case (state)
            jtag_config_port_pkg::TLR: next_state = tms_sync[1] ? jtag_config_port_pkg::TLR : jtag_config_port_pkg::RTI;
            jtag_config_port_pkg::RTI: next_state = tms_sync[1] ? jtag_config_port_pkg::SEL_DR : jtag_config_port_pkg::RTI;
            jtag_config_port_pkg::SEL_DR: next_state = tms_sync[1] ? jtag_config_port_pkg::SEL_IR : jtag_config_port_pkg::CAP_DR;
            jtag_config_port_pkg::CAP_DR: next_state = tms_sync[1] ? jtag_config_port_pkg::EX1_DR : jtag_config_port_pkg::SH_DR;
            jtag_config_port_pkg::SH_DR: next_state = tms_sync[1] ? jtag_config_port_pkg::EX1_DR : jtag_config_port_pkg::SH_DR;
            jtag_config_port_pkg::EX1_DR: next_state = tms_sync[1] ? jtag_config_port_pkg::UPD_DR : jtag_config_port_pkg::PA_DR;
            jtag_config_port_pkg::PA_DR: next_state = tms_sync[1] ? jtag_config_port_pkg::EX2_DR : jtag_config_port_pkg::PA_DR;
            jtag_config_port_pkg::EX2_DR: next_state = tms_sync[1] ? jtag_config_port_pkg::UPD_DR : jtag_config_port_pkg::SH_DR;
            jtag_config_port_pkg::UPD_DR: next_state = tms_sync[1] ? jtag_config_port_pkg::SEL_DR : jtag_config_port_pkg::RTI;
            jtag_config_port_pkg::SEL_IR: next_state = tms_sync[1] ? jtag_config_port_pkg::TLR : jtag_config_port_pkg::CAP_IR;
            jtag_config_port_pkg::CAP_IR: next_state = tms_sync[1] ? jtag_config_port_pkg::EX1_IR : jtag_config_port_pkg::SH_IR;
            jtag_config_port_pkg::SH_IR: next_state = tms_sync[1] ? jtag_config_port_pkg::EX1_IR : jtag_config_port_pkg::SH_IR;
            jtag_config_port_pkg::EX1_IR: next_state = tms_sync[1] ? jtag_config_port_pkg::UPD_IR : jtag_config_port_pkg::PA_IR;
            jtag_config_port_pkg::PA_IR: next_state = tms_sync[1] ? jtag_config_port_pkg::EX2_IR : jtag_config_port_pkg::PA_IR;
            jtag_config_port_pkg::EX2_IR: next_state = tms_sync[1] ? jtag_config_port_pkg::UPD_IR : jtag_config_port_pkg::SH_IR;
            jtag_config_port_pkg::UPD_IR: next_state = tms_sync[1] ? jtag_config_port_pkg::SEL_DR : jtag_config_port_pkg::RTI;
            default: next_state = jtag_config_port_pkg::TLR;
        endcase
    end

    // state steps only on a test clock rising edge
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state <= jtag_config_port_pkg::TLR;
        end else if (tck_rise) begin
            state <= next_state;
        end
    end

    // ----------------------------------------
    // instruction register
    // ----------------------------------------
    logic [jtag_config_port_pkg::IR_WIDTH-1:0] ir_shift, instr;

    // test-logic-reset loads the identification instruction
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ir_shift <= jtag_config_port_pkg::IR_CAPTURE;
            instr <= jtag_config_port_pkg::INSTR_IDCODE;
        end else if (tck_rise) begin
            case (state)
                jtag_config_port_pkg::TLR: instr <= jtag_config_port_pkg::INSTR_IDCODE;
                jtag_config_port_pkg::CAP_IR: ir_shift <= jtag_config_port_pkg::IR_CAPTURE;
                jtag_config_port_pkg::SH_IR: ir_shift <= {tdi_sync[1], ir_shift[4:1]};
                jtag_config_port_pkg::UPD_IR: instr <= ir_shift;
                default: ;
            endcase
        end
    end

    // ----------------------------------------
    // data path selection
    // ----------------------------------------
    // any code without a register of its own falls to bypass
    function automatic logic [1:0] dr_select(input logic [4:0] code);
        case (code)
            jtag_config_port_pkg::INSTR_IDCODE: dr_select = 2'd1;
            jtag_config_port_pkg::SELECT_CONFIG_REG_INSTR,
            jtag_config_port_pkg::READBACK_CONFIG_INSTR: dr_select = 2'd2;
            default: dr_select = 2'd0;
        endcase
    endfunction

    logic [1:0] dr_sel;
    assign dr_sel = dr_select(instr);

    // ----------------------------------------
    // data registers
    // ----------------------------------------
    logic bypass_stage;
    logic [jtag_config_port_pkg::ID_WIDTH-1:0] id_shift;
    logic [CFG_W-1:0] cfg_shift, nv_cells;
    logic [CFG_W-1:0] readback_view;

    // functional bits read as zero once locked; signature stays visible
    always_comb begin
        readback_view = nv_cells;
        if (nv_cells[jtag_config_port_pkg::LOCK_POS]) begin
            readback_view[jtag_config_port_pkg::SIG_LSB-1:0] = '0;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            bypass_stage <= 1'b0;
            id_shift <= '0;
            cfg_shift <= '0;
        end else if (tck_rise) begin
            if (state == jtag_config_port_pkg::CAP_DR) begin
                bypass_stage <= 1'b0;
                id_shift <= jtag_config_port_pkg::ID_VALUE;
                if (instr == jtag_config_port_pkg::READBACK_CONFIG_INSTR) begin
                    cfg_shift <= readback_view;
                end
            end else if (state == jtag_config_port_pkg::SH_DR) begin
                case (dr_sel)
                    2'd1: id_shift <= {tdi_sync[1], id_shift[31:1]};
                    2'd2: cfg_shift <= {tdi_sync[1], cfg_shift[CFG_W-1:1]};
                    default: bypass_stage <= tdi_sync[1];
                endcase
            end
        end
    end

    // ----------------------------------------
    // nonvolatile cells
    // ----------------------------------------
    // commit and erase run on entry to idle after the instruction update;
    // stands in for the slow cell write, done in one step here
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            nv_cells <= '0;
        end else if (tck_rise && state == jtag_config_port_pkg::UPD_IR && !tms_sync[1]) begin
            if (ir_shift == jtag_config_port_pkg::COMMIT_CONFIG_INSTR) begin
                nv_cells <= nv_cells | cfg_shift;   // cells only program toward one
            end else if (ir_shift == jtag_config_port_pkg::INSTR_ERASE) begin
                nv_cells <= '0;
            end
        end
    end

    // ----------------------------------------
    // serial output and core outputs
    // ----------------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            tdo <= 1'b0;
            tdo_oe <= 1'b0;
        end else if (tck_fall) begin
            tdo_oe <= (state == jtag_config_port_pkg::SH_DR) || (state == jtag_config_port_pkg::SH_IR);
            if (state == jtag_config_port_pkg::SH_IR) begin
                tdo <= ir_shift[0];
            end else begin
                case (dr_sel)
                    2'd1: tdo <= id_shift[0];
                    2'd2: tdo <= cfg_shift[0];
                    default: tdo <= bypass_stage;
                endcase
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            config_bits <= '0;
            security_lock_bit <= 1'b0;
            user_signature_bits <= '0;
        end else begin
            config_bits <= nv_cells;
            security_lock_bit <= nv_cells[jtag_config_port_pkg::LOCK_POS];
            user_signature_bits <= nv_cells[jtag_config_port_pkg::SIG_LSB +: jtag_config_port_pkg::SIG_WIDTH];
        end
    end

endmodule // jtag_config_port

// >>> verification/jtag_config_port_sva.sv
`timescale 1ns/1ps
module jtag_config_port_sva #(
    parameter int CFG_W = 24
) (
    // system
    input wire logic ref_clk,
    input wire logic rst,
    // test port pins
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    input wire logic tdo,
    input wire logic tdo_oe,
    // configuration image
    input wire logic [CFG_W-1:0] config_bits,
    input wire logic security_lock_bit,
    input wire logic [6:0] user_signature_bits
);
    // one domain only, so clock and reset are given once
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    a_lock_in_image: assert property (security_lock_bit == config_bits[CFG_W-1])
        else $error("lock output differs from image top bit");
    a_sig_in_image: assert property (user_signature_bits == config_bits[22:16])
        else $error("signature output differs from image field");
    a_oe_after_reset: assert property ($fell(rst) |-> !tdo_oe [*2])
        else $error("serial output driven right after reset");
    a_tdo_on_fall: assert property ($changed(tdo) |-> !tck)
        else $error("serial output moved while test clock high");
    a_oe_on_fall: assert property ($changed(tdo_oe) |-> !tck)
        else $error("output enable moved while test clock high");
    a_cfg_on_rise: assert property ($changed(config_bits) |-> tck)
        else $error("image changed away from a test clock rise");
    a_lock_sticky: assert property ($fell(security_lock_bit) |-> config_bits == '0)
        else $error("lock cleared without full erase");
    a_cfg_only_grows: assert property ($changed(config_bits) |->
        (config_bits == '0) || ((config_bits & $past(config_bits)) == $past(config_bits)))
        else $error("commit cleared a programmed cell");
endmodule // jtag_config_port_sva

// >>> verification/jtag_programmer.sv
`timescale 1ns/1ps
module jtag_programmer (
    // test port
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo_line
);
    // clock parks low between frames, never free running
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end

    // one test clock: drive after fall, sample the answer at the rise
    task automatic step(input logic m, input logic d, output logic q);
        tms = m;
        tdi = d;
        #62.5;
        q = tdo_line;
        tck = 1'b1;
        #62.5;
        tck = 1'b0;
    endtask

    // five high mode bits reach reset from any state, then idle
    task automatic tap_reset();
        logic q;
        repeat (5) step(1'b1, 1'b0, q);
        step(1'b0, 1'b0, q);
    endtask

    // idle to idle scan, lsb first; update then idle fires commit and erase
    task automatic scan(input logic is_ir, input int n, input logic [31:0] din, output logic [31:0] dout);
        logic q;
        dout = '0;
        step(1'b1, 1'b0, q);
        if (is_ir) begin
            step(1'b1, 1'b0, q);
        end
        step(1'b0, 1'b0, q);
        step(1'b0, 1'b0, q);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], q);
            dout[i] = q;
        end
        step(1'b1, 1'b0, q);
        step(1'b0, 1'b0, q);
        tdi = ~tdi; // released data line does not keep its last value
    endtask
endmodule // jtag_programmer

// >>> verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    localparam int CFG_W = 24;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic tck, tms, tdi, tdo, tdo_oe, tdo_line, security_lock_bit;
    logic [CFG_W-1:0] config_bits;
    logic [6:0] user_signature_bits;
    logic [31:0] img, q, d;
    logic [4:0] byp [4] = '{5'h00, 5'h1e, 5'h1f, 5'h1c};
    int miscompares = 0;
    int num_checks = 0;

    always #2 ref_clk = ~ref_clk;
    // board pull-up holds the line high whenever the port lets go
    assign tdo_line = tdo_oe ? tdo : 1'b1;

    jtag_config_port #(.CFG_W(CFG_W)) dut (.ref_clk(ref_clk), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi),
        .tdo(tdo), .tdo_oe(tdo_oe), .config_bits(config_bits), .security_lock_bit(security_lock_bit),
        .user_signature_bits(user_signature_bits));
    jtag_programmer prog (.tck(tck), .tms(tms), .tdi(tdi), .tdo_line(tdo_line));

    // ----------------------------------------
    // checking and model helpers
    // ----------------------------------------
    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task summarize();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    task ir(input logic [4:0] code);
        prog.scan(1'b1, 5, {27'h0, code}, q);
        check("ir capture", q[4:0], 5'h01);
        check("oe idle", {31'h0, tdo_oe}, 32'h0);
    endtask

    // model: cells only program towards one
    task commit(input logic [23:0] data);
        ir(jtag_config_port_pkg::SELECT_CONFIG_REG_INSTR);
        prog.scan(1'b0, CFG_W, {8'h0, data}, q);
        ir(jtag_config_port_pkg::COMMIT_CONFIG_INSTR);
        img = img | {8'h0, data};
        check("config", {8'h0, config_bits}, img);
        check("signature", {25'h0, user_signature_bits}, {25'h0, img[22:16]});
        check("lock", {31'h0, security_lock_bit}, {31'h0, img[23]});
    endtask

    // locked image hides only the functional bits
    task readback();
        ir(jtag_config_port_pkg::READBACK_CONFIG_INSTR);
        prog.scan(1'b0, CFG_W, 32'h0, q);
        check("readback", q & 32'hff_ffff, img[23] ? (img & 32'hff_0000) : img);
    endtask

    initial begin
        d = $urandom(32'hc4abecf1);
        img = '0;
        repeat (4) @(posedge ref_clk);
        #1 rst = 1'b0;
        // quarter-ns offset keeps every test clock edge off a system clock edge
        #0.25;
        prog.tap_reset();
        prog.scan(1'b0, 32, 32'h0, q);
        check("idcode", q, jtag_config_port_pkg::ID_VALUE);
        $display("test identification done");
        for (int i = 0; i < 4; i++) begin
            ir(byp[i]);
            d = $urandom;
            prog.scan(1'b0, 9, d, q);
            check("bypass", {24'h0, q[8:1]}, {24'h0, d[7:0]});
        end
        $display("test bypass done");
        d = $urandom & 32'h7f_ffff;
        commit(d[23:0]);
        readback();
        d = $urandom;
        commit(d[23:0]);
        commit(24'h80_0000);
        readback();
        $display("test commit and lock done");
        ir(jtag_config_port_pkg::INSTR_ERASE);
        img = '0;
        check("erase", {8'h0, config_bits}, img);
        check("lock erased", {31'h0, security_lock_bit}, 32'h0);
        readback();
        $display("test erase done");
        ir(jtag_config_port_pkg::INSTR_IDCODE);
        prog.scan(1'b0, 32, 32'h0, q);
        check("idcode instr", q, jtag_config_port_pkg::ID_VALUE);
        $display("test identification instruction done");
        summarize();
    end

    // watchdog: a hung port ends the run as a mismatch
    initial begin
        repeat (100000) @(posedge ref_clk);
        miscompares++;
        $display("[ERR] watchdog expected finish seen hang");
        summarize();
    end
endmodule // tb_top

bind jtag_config_port jtag_config_port_sva #(.CFG_W(CFG_W)) u_sva (.ref_clk(ref_clk), .rst(rst), .tck(tck),
    .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .config_bits(config_bits),
    .security_lock_bit(security_lock_bit), .user_signature_bits(user_signature_bits));
